// ==== mmucsr_defines.svh ====
`ifndef MMUCSR_DEFINES_SVH
`define MMUCSR_DEFINES_SVH

// ----------------------------------------
// register selects
// ----------------------------------------
`define MMUCSR_SEL_BASE0 3'h0
`define MMUCSR_SEL_BASE1 3'h1
`define MMUCSR_SEL_INV0 3'h2
`define MMUCSR_SEL_INV1 3'h3
`define MMUCSR_SEL_FAULT 3'h4
`define MMUCSR_SEL_CTRL 3'h5
`define MMUCSR_SEL_STAT 3'h6

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define MMUCSR_PTB_ZERO_BITS 12
`define MMUCSR_CTRL_BITS 4
`define MMUCSR_STAT_BITS 8
`define MMUCSR_CTRL_USER_EN 0
`define MMUCSR_CTRL_SUPV_EN 1
`define MMUCSR_CTRL_DUAL 2
`define MMUCSR_CTRL_OVRD 3
`define MMUCSR_STAT_DIR 2
`define MMUCSR_STAT_PRIV 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define MMUCSR_RST_WORD 32'h0000_0000
`define MMUCSR_RST_CTRL 4'h0
`define MMUCSR_RST_STAT 8'h00

// ----------------------------------------
// cause codes
// ----------------------------------------
`define MMUCSR_CAUSE_NONE 2'h0
`define MMUCSR_CAUSE_L1 2'h1
`define MMUCSR_CAUSE_L2 2'h2
`define MMUCSR_CAUSE_PROT 2'h3

`endif

// ==== mmucsr_pkg.sv ====
package mmucsr_pkg;
  typedef enum logic [3:0] {
    MMUCSR_KIND_SEQ_FETCH = 4'h8,
    MMUCSR_KIND_NONSEQ_FETCH = 4'h9,
    MMUCSR_KIND_DATA = 4'ha,
    MMUCSR_KIND_RMW_READ = 4'hb,
    MMUCSR_KIND_EA_READ = 4'hc
  } mmucsr_ref_kind_t;
endpackage

// ==== mmucsr_fault_if.sv ====
`timescale 1ns/10ps
interface mmucsr_fault_if;
  logic valid;
  logic [31:0] vaddr;
  logic [1:0] cause;
  logic is_write;
  logic is_user;
  logic [3:0] cpu_status;
  logic needed;
  modport src (output valid, vaddr, cause, is_write, is_user, cpu_status, needed);
  modport dst (input valid, vaddr, cause, is_write, is_user, cpu_status, needed);
endinterface

// ==== mmucsr_fault_cap.sv ====
`timescale 1ns/10ps
`include "mmucsr_defines.svh"
module mmucsr_fault_cap (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // translation checker results
  input wire logic check_in,
  input wire logic [31:0] vaddr_in,
  input wire logic invalid_l1_in,
  input wire logic invalid_l2_in,
  input wire logic prot_viol_in,
  input wire logic is_write_in,
  input wire logic is_user_in,
  input wire mmucsr_pkg::mmucsr_ref_kind_t ref_kind_in,
  input wire logic discarded_in,
  // registered fault event
  mmucsr_fault_if.src flt
);
  logic [1:0] cause;

  always_comb begin
    cause = `MMUCSR_CAUSE_NONE;
    if (prot_viol_in) begin
      cause = `MMUCSR_CAUSE_PROT;
    end else if (invalid_l2_in) begin
      cause = `MMUCSR_CAUSE_L2;
    end else if (invalid_l1_in) begin
      cause = `MMUCSR_CAUSE_L1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flt.valid <= 1'b0;
      flt.vaddr <= `MMUCSR_RST_WORD;
      flt.cause <= `MMUCSR_CAUSE_NONE;
      flt.is_write <= 1'b0;
      flt.is_user <= 1'b0;
      flt.cpu_status <= 4'h0;
      flt.needed <= 1'b0;
    end else begin
      flt.valid <= check_in && (cause != `MMUCSR_CAUSE_NONE);
      flt.vaddr <= vaddr_in;
      flt.cause <= cause;
      flt.is_write <= is_write_in;
      flt.is_user <= is_user_in;
      flt.cpu_status <= ref_kind_in;
      flt.needed <= !discarded_in;
    end
  end
endmodule

// ==== mmucsr_tlb_purge.sv ====
`timescale 1ns/10ps
module mmucsr_tlb_purge (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // purge requests from register writes
  input wire logic base_load_in,
  input wire logic base_sel_in,
  input wire logic vaddr_purge_in,
  input wire logic [31:0] vaddr_in,
  // registered purge command
  output logic all_purge_out,
  output logic all_base_sel_out,
  output logic one_purge_out,
  output logic [31:0] one_vaddr_out
);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      all_purge_out <= 1'b0;
      all_base_sel_out <= 1'b0;
      one_purge_out <= 1'b0;
      one_vaddr_out <= 32'h0000_0000;
    end else begin
      all_purge_out <= base_load_in;
      all_base_sel_out <= base_sel_in;
      one_purge_out <= vaddr_purge_in;
      if (vaddr_purge_in) begin
        one_vaddr_out <= vaddr_in;
      end
    end
  end
endmodule

// ==== mmucsr_top.sv ====
`timescale 1ns/10ps
`include "mmucsr_defines.svh"
module mmucsr_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // load/store mmu register instructions
  input wire logic load_mmu_reg_instr_in,
  input wire logic store_mmu_reg_instr_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out,
  output logic rvalid_out,
  // reference being translated
  input wire logic ref_user_in,
  output logic translate_out,
  output logic [31:0] table_base_out,
  output logic supervisor_priv_out,
  // translation checker results
  input wire logic check_in,
  input wire logic [31:0] check_vaddr_in,
  input wire logic invalid_l1_in,
  input wire logic invalid_l2_in,
  input wire logic prot_viol_in,
  input wire logic is_write_in,
  input wire mmucsr_pkg::mmucsr_ref_kind_t ref_kind_in,
  input wire logic discarded_in,
  // results
  output logic abort_trap_out,
  output logic all_purge_out,
  output logic all_base_sel_out,
  output logic one_purge_out,
  output logic [31:0] one_vaddr_out
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:`MMUCSR_PTB_ZERO_BITS] page_table_base_0_ff;
  logic [31:`MMUCSR_PTB_ZERO_BITS] page_table_base_1_ff;
  logic [31:0] fault_vaddr_ff;
  logic [`MMUCSR_CTRL_BITS-1:0] translation_control_ff;
  logic [`MMUCSR_STAT_BITS-1:0] translation_status_ff;
  logic wr_base0, wr_base1, wr_inv, take_fault, use_base1;
  mmucsr_fault_if flt ();

  assign wr_base0 = load_mmu_reg_instr_in && (reg_sel_in == `MMUCSR_SEL_BASE0);
  assign wr_base1 = load_mmu_reg_instr_in && (reg_sel_in == `MMUCSR_SEL_BASE1);
  assign wr_inv = load_mmu_reg_instr_in && ((reg_sel_in == `MMUCSR_SEL_INV0) ||
                  (reg_sel_in == `MMUCSR_SEL_INV1));
  assign take_fault = flt.valid && flt.needed;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      page_table_base_0_ff <= '0;
      page_table_base_1_ff <= '0;
    end else begin
      if (wr_base0) begin
        page_table_base_0_ff <= wdata_in[31:`MMUCSR_PTB_ZERO_BITS];
      end
      if (wr_base1) begin
        page_table_base_1_ff <= wdata_in[31:`MMUCSR_PTB_ZERO_BITS];
      end
    end
  end

  // control writes never purge anything
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      translation_control_ff <= `MMUCSR_RST_CTRL;
    end else if (load_mmu_reg_instr_in && reg_sel_in == `MMUCSR_SEL_CTRL) begin
      translation_control_ff <= wdata_in[`MMUCSR_CTRL_BITS-1:0];
    end
  end

  // hardware capture wins over a software write in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_vaddr_ff <= `MMUCSR_RST_WORD;
      translation_status_ff <= `MMUCSR_RST_STAT;
    end else if (take_fault) begin
      fault_vaddr_ff <= flt.vaddr;
      translation_status_ff <= {flt.cpu_status, flt.is_user, flt.is_write,
                                flt.cause};
    end else if (load_mmu_reg_instr_in) begin
      if (reg_sel_in == `MMUCSR_SEL_FAULT) begin
        fault_vaddr_ff <= wdata_in;
      end
      if (reg_sel_in == `MMUCSR_SEL_STAT) begin
        translation_status_ff <= wdata_in[`MMUCSR_STAT_BITS-1:0];
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= `MMUCSR_RST_WORD;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= store_mmu_reg_instr_in;
      case (reg_sel_in)
        `MMUCSR_SEL_BASE0: rdata_out <= {page_table_base_0_ff, 12'h000};
        `MMUCSR_SEL_BASE1: rdata_out <= {page_table_base_1_ff, 12'h000};
        `MMUCSR_SEL_FAULT: rdata_out <= fault_vaddr_ff;
        `MMUCSR_SEL_CTRL: rdata_out <= {28'h0, translation_control_ff};
        `MMUCSR_SEL_STAT: rdata_out <= {24'h0, translation_status_ff};
        default: rdata_out <= `MMUCSR_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // translation steering
  // ----------------------------------------
  assign use_base1 = translation_control_ff[`MMUCSR_CTRL_DUAL] && ref_user_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      translate_out <= 1'b0;
      table_base_out <= `MMUCSR_RST_WORD;
      supervisor_priv_out <= 1'b0;
      abort_trap_out <= 1'b0;
    end else begin
      translate_out <= ref_user_in ? translation_control_ff[`MMUCSR_CTRL_USER_EN]
                                   : translation_control_ff[`MMUCSR_CTRL_SUPV_EN];
      table_base_out <= use_base1 ? {page_table_base_1_ff, 12'h000}
                                  : {page_table_base_0_ff, 12'h000};
      supervisor_priv_out <= !ref_user_in ||
                             translation_control_ff[`MMUCSR_CTRL_OVRD];
      abort_trap_out <= take_fault;
    end
  end

  mmucsr_fault_cap u_cap (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .check_in(check_in),
    .vaddr_in(check_vaddr_in),
    .invalid_l1_in(invalid_l1_in),
    .invalid_l2_in(invalid_l2_in),
    .prot_viol_in(prot_viol_in),
    .is_write_in(is_write_in),
    .is_user_in(ref_user_in),
    .ref_kind_in(ref_kind_in),
    .discarded_in(discarded_in),
    .flt(flt)
  );

  mmucsr_tlb_purge u_purge (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .base_load_in(wr_base0 || wr_base1),
    .base_sel_in(wr_base1),
    .vaddr_purge_in(wr_inv),
    .vaddr_in(wdata_in),
    .all_purge_out(all_purge_out),
    .all_base_sel_out(all_base_sel_out),
    .one_purge_out(one_purge_out),
    .one_vaddr_out(one_vaddr_out)
  );
endmodule

// ==== mmucsr_monitor.sv ====
`timescale 1ns/10ps
module mmucsr_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register access
  input wire logic load_mmu_reg_instr_in,
  input wire logic store_mmu_reg_instr_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [31:0] wdata_in,
  input wire logic [31:0] rdata_out,
  input wire logic rvalid_out,
  // faults and purges
  input wire logic check_in,
  input wire logic invalid_l1_in,
  input wire logic invalid_l2_in,
  input wire logic prot_viol_in,
  input wire logic discarded_in,
  input wire logic abort_trap_out,
  input wire logic all_purge_out,
  input wire logic all_base_sel_out,
  input wire logic one_purge_out,
  input wire logic [31:0] one_vaddr_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic rd, wr, flt;
  assign rd = store_mmu_reg_instr_in;
  assign wr = load_mmu_reg_instr_in;
  assign flt = check_in && !discarded_in && (invalid_l1_in || invalid_l2_in || prot_viol_in);
  rd_answer_a: assert property (rd |=> rvalid_out)
    else $error("read not answered");
  wo_read_a: assert property (rd && reg_sel_in inside {3'h2, 3'h3, 3'h7} |=> rdata_out == '0)
    else $error("write-only read not zero");
  base_align_a: assert property (rd && reg_sel_in < 3'h2 |=> rdata_out[11:0] == 12'h000)
    else $error("base low bits not zero");
  base_purge_a: assert property (wr && reg_sel_in < 3'h2 |=> all_purge_out &&
    all_base_sel_out == $past(reg_sel_in[0])) else $error("base load purge wrong");
  inv_purge_a: assert property (wr && reg_sel_in inside {3'h2, 3'h3} |=> one_purge_out &&
    one_vaddr_out == $past(wdata_in)) else $error("invalidate purge wrong");
  no_purge_a: assert property (wr && reg_sel_in > 3'h3 |=> !all_purge_out && !one_purge_out)
    else $error("purge without cause");
  ctrl_upper_a: assert property (rd && reg_sel_in == 3'h5 |=> rdata_out[31:4] == 28'h0)
    else $error("control upper bits not zero");
  stat_upper_a: assert property (rd && reg_sel_in == 3'h6 |=> rdata_out[31:8] == 24'h0)
    else $error("status upper bits not zero");
  abort_raise_a: assert property (flt |-> ##2 abort_trap_out)
    else $error("abort not raised");
  abort_cause_a: assert property (abort_trap_out |-> $past(flt, 2))
    else $error("abort without needed fault");
  cover property (abort_trap_out);
  cover property (one_purge_out);
  cover property (all_purge_out && all_base_sel_out);
endmodule
bind mmucsr_top mmucsr_monitor u_mon (.clk_in(clk_in), .rst_in(rst_in),
  .load_mmu_reg_instr_in(load_mmu_reg_instr_in), .store_mmu_reg_instr_in(store_mmu_reg_instr_in),
  .reg_sel_in(reg_sel_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .check_in(check_in), .invalid_l1_in(invalid_l1_in), .invalid_l2_in(invalid_l2_in),
  .prot_viol_in(prot_viol_in), .discarded_in(discarded_in), .abort_trap_out(abort_trap_out),
  .all_purge_out(all_purge_out), .all_base_sel_out(all_base_sel_out),
  .one_purge_out(one_purge_out), .one_vaddr_out(one_vaddr_out));

// ==== mmucsr_top_tb.sv ====
`timescale 1ns/10ps
module mmucsr_top_tb;
  logic clk_in = 1'b0, rst_in = 1'b1;
  logic load_mmu_reg_instr_in = 1'b0, store_mmu_reg_instr_in = 1'b0;
  logic [2:0] reg_sel_in = 3'h0;
  logic [31:0] wdata_in = 32'h0, check_vaddr_in = 32'h0, rdata_out, table_base_out, one_vaddr_out;
  logic ref_user_in = 1'b0, check_in = 1'b0, invalid_l1_in = 1'b0, invalid_l2_in = 1'b0;
  logic prot_viol_in = 1'b0, is_write_in = 1'b0, discarded_in = 1'b0;
  mmucsr_pkg::mmucsr_ref_kind_t ref_kind_in = mmucsr_pkg::MMUCSR_KIND_DATA;
  logic rvalid_out, translate_out, supervisor_priv_out, abort_trap_out;
  logic all_purge_out, all_base_sel_out, one_purge_out;
  int n_fail = 0, check_count = 0;
  // select, write data, read back
  logic [66:0] rows [8] = '{{3'h0, 32'hffff_ffff, 32'hffff_f000},
    {3'h1, 32'h1234_5abc, 32'h1234_5000}, {3'h2, 32'hdead_beef, 32'h0},
    {3'h3, 32'h5555_aaaa, 32'h0}, {3'h4, 32'hcafe_f00d, 32'hcafe_f00d},
    {3'h5, 32'h0000_000a, 32'h0000_000a}, {3'h6, 32'hffff_ff5a, 32'h0000_005a},
    {3'h7, 32'hffff_ffff, 32'h0}};
  // kind, discarded, user, write, prot, l2, l1
  logic [9:0] frows [7] = '{10'h201, 10'h25a, 10'h295, 10'h2ce, 10'h304, 10'h231, 10'h288};
  mmucsr_top u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .load_mmu_reg_instr_in(load_mmu_reg_instr_in),
    .store_mmu_reg_instr_in(store_mmu_reg_instr_in), .reg_sel_in(reg_sel_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .ref_user_in(ref_user_in), .translate_out(translate_out),
    .table_base_out(table_base_out), .supervisor_priv_out(supervisor_priv_out),
    .check_in(check_in), .check_vaddr_in(check_vaddr_in), .invalid_l1_in(invalid_l1_in),
    .invalid_l2_in(invalid_l2_in), .prot_viol_in(prot_viol_in), .is_write_in(is_write_in),
    .ref_kind_in(ref_kind_in), .discarded_in(discarded_in),
    .abort_trap_out(abort_trap_out), .all_purge_out(all_purge_out),
    .all_base_sel_out(all_base_sel_out), .one_purge_out(one_purge_out),
    .one_vaddr_out(one_vaddr_out));
  always #2 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge clk_in);
    load_mmu_reg_instr_in <= 1'b1;
    reg_sel_in <= s;
    wdata_in <= d;
    @(posedge clk_in);
    load_mmu_reg_instr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] s, output logic [31:0] q);
    @(posedge clk_in);
    store_mmu_reg_instr_in <= 1'b1;
    reg_sel_in <= s;
    @(posedge clk_in);
    store_mmu_reg_instr_in <= 1'b0;
    #1;
    chk("rvalid", rvalid_out, 32'h1);
    q = rdata_out;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    final_report();
  end
  initial begin
    logic [31:0] q, va, fva;
    logic [9:0] f;
    logic [7:0] stat;
    logic hit;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(3'h5, q);
    chk("reset control", q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][66:64], rows[i][63:32]);
      chk("all_purge", all_purge_out, rows[i][66:65] == 2'h0);
      chk("one_purge", one_purge_out, rows[i][66:65] == 2'h1);
      chk("base_sel", all_base_sel_out, rows[i][66:64] == 3'h1);
      if (rows[i][66:65] == 2'h1) chk("one_vaddr", one_vaddr_out, rows[i][63:32]);
      rd(rows[i][66:64], q);
      chk("rdata", q, rows[i][31:0]);
    end
    for (int c = 0; c < 32; c++) begin
      wr(3'h5, {28'h0, c[3:0]});
      @(posedge clk_in);
      ref_user_in <= c[4];
      @(posedge clk_in);
      #1;
      chk("translate", translate_out, c[4] ? c[0] : c[1]);
      chk("base", table_base_out, c[4] && c[2] ? 32'h1234_5000 : 32'hffff_f000);
      chk("priv", supervisor_priv_out, !c[4] || c[3]);
    end
    fva = 32'hcafe_f00d;
    stat = 8'h5a;
    for (int i = 0; i < 7; i++) begin
      f = frows[i];
      va = 32'h9abc_def1 + i * 32'h1234_5678;
      @(posedge clk_in);
      check_in <= 1'b1;
      check_vaddr_in <= va;
      ref_kind_in <= mmucsr_pkg::mmucsr_ref_kind_t'(f[9:6]);
      {discarded_in, ref_user_in, is_write_in, prot_viol_in, invalid_l2_in, invalid_l1_in} <= f[5:0];
      @(posedge clk_in);
      check_in <= 1'b0;
      hit = |f[2:0] && !f[5];
      if (hit) begin
        stat = {f[9:6], f[4], f[3], f[2] ? 2'h3 : (f[1] ? 2'h2 : 2'h1)};
        fva = va;
      end
      @(posedge clk_in);
      #1;
      chk("abort", abort_trap_out, hit);
      rd(3'h4, q);
      chk("fault_vaddr", q, fva);
      rd(3'h6, q);
      chk("status", q, {24'h0, stat});
    end
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    chk("reset abort", abort_trap_out, 32'h0);
    chk("reset purge", all_purge_out, 32'h0);
    rd(3'h4, q);
    chk("reset fault_vaddr", q, 32'h0);
    rd(3'h6, q);
    chk("reset status", q, 32'h0);
    rd(3'h0, q);
    chk("reset base", q, 32'h0);
    final_report();
  end
endmodule
